// *** core/freq_meas_pkg.sv ***
// constants, register map and field layout of the gated frequency counter
// assumes a 50 MHz system clock and a 32-bit apb register bus
package freq_meas_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int SLOW_CLK_HZ = 32_768;
  localparam int SLOW_DIV_CYCLES = CLK_HZ / SLOW_CLK_HZ;
  localparam logic [10:0] SLOW_DIV_LAST = 11'(SLOW_DIV_CYCLES - 1);

  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] CNT_MAX = 18'h3ffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;

  localparam int FAST_DIV_W = 14;
  localparam int SLOW_UNIT_W = 6;
  localparam logic [3:0] FAST_BASE_EXP = 4'hc;
  localparam logic [3:0] SLOW_BASE_EXP = 4'h4;
  localparam logic [1:0] PRESCALE_MAX = 2'h2;
  localparam logic [4:0] PERIOD_SPAN = 5'h10;

  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_GATE_PERIOD = 12'h004;
  localparam logic [11:0] OFS_COUNT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h010;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h014;

  localparam int CTRL_CLEAR_BIT = 8;
  localparam int STAT_GATE_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam logic [1:0] GATE_SRC_PIN = 2'h0;

  typedef struct packed {
    logic source_clock_select;
    logic divider_stage_select;
    logic [1:0] gate_prescale_select;
    logic gate_irq_edge_select;
    logic [1:0] gate_source_select;
    logic run;
  } timer1_control_t;

  localparam timer1_control_t CTRL_RESET = 8'h00;

  typedef struct packed {
    logic [3:0] gate_low_setting;
    logic [3:0] gate_high_setting;
  } gate_period_t;

  localparam gate_period_t PERIOD_RESET = 8'h00;

  typedef struct packed {
    logic overflow;
    logic gate_edge;
  } irq_bits_t;

  typedef enum logic [1:0] {
    GATE_IDLE = 2'b00,
    GATE_HIGH = 2'b01,
    GATE_LOW = 2'b11
  } gate_state_t;
endpackage

// *** core/window_gate_gen.sv ***
// internal window gate generator: high period then low period, repeating
// assumes a one-cycle prescale unit tick from a free-running divider
`timescale 1ns/10ps
module window_gate_gen (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_unit_tick,
  input freq_meas_pkg::gate_period_t i_period,
  output logic o_gate
);
  import freq_meas_pkg::*;

  gate_state_t state_reg, state_next;
  logic [4:0] units_reg, units_next;

  always_comb begin
    state_next = state_reg;
    units_next = units_reg;
    if (!i_run) begin
      state_next = GATE_IDLE;
      units_next = PERIOD_SPAN;
    end else if (i_unit_tick) begin
      case (state_reg)
        GATE_IDLE: begin
          // first window waits for the divider RQ12
          state_next = GATE_HIGH;
          units_next = PERIOD_SPAN - {1'b0, i_period.gate_high_setting}; // RQ11
        end
        GATE_HIGH: begin
          if (units_reg <= 5'h1) begin
            state_next = GATE_LOW; // RQ10
            // low setting latched at the start of each low period RQ13
            units_next = PERIOD_SPAN - {1'b0, i_period.gate_low_setting}; // RQ11
          end else begin
            units_next = units_reg - 5'h1;
          end
        end
        GATE_LOW: begin
          if (units_reg <= 5'h1) begin
            state_next = GATE_HIGH; // RQ10
            units_next = PERIOD_SPAN - {1'b0, i_period.gate_high_setting};
          end else begin
            units_next = units_reg - 5'h1;
          end
        end
        default: begin
          state_next = GATE_IDLE;
          units_next = PERIOD_SPAN;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= GATE_IDLE;
      units_reg <= PERIOD_SPAN;
    end else begin
      state_reg <= state_next;
      units_reg <= units_next;
    end
  end

  assign o_gate = (state_reg == GATE_HIGH);
endmodule

// *** core/gated_frequency_measurement.sv ***
// gated frequency measurement timer with apb registers and interrupt
// assumes event and gate pins synchronous to i_mclk, apb master on i_mclk
//
// Contract
// RQ1: count events only while window gate high
// RQ2: software selects external clock before measuring
// RQ3: gate source 00 selects external gate pin
// RQ4: interrupt on gate fall or both edges
// RQ5: software reads count in low, then clears
// RQ6: uncleared counter resumes from previous value
// RQ7: gate level readable as status flag
// RQ8: wrap 3ffff to 0 sets overflow flag
// RQ9: overflow flag held until counter clear
// RQ10: internal gate alternates high and low periods
// RQ11: period is (16 - setting) prescale units
// RQ12: first internal window may lag one unit
// RQ13: low setting change applies next low period
// RQ14: count falling edges of event AND gate
// RQ15: counter frozen while gate low
`timescale 1ns/10ps
module gated_frequency_measurement (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_event_count_input,
  input wire logic i_external_gate_input,
  output logic o_timer1_interrupt
);
  import freq_meas_pkg::*;

  // reset release synchroniser
  logic rst_meta_reg, rst_sync_reg;
  logic rst_n;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // register state
  timer1_control_t timer1_control_one_reg, timer1_control_one_next;
  gate_period_t gate_period_setting_reg, gate_period_setting_next;
  irq_bits_t irq_status_reg, irq_status_next;
  irq_bits_t irq_mask_reg, irq_mask_next;
  logic [CNT_W-1:0] count_result_value_reg, count_result_value_next;
  logic count_overflow_flag_reg, count_overflow_flag_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;

  // counting state
  logic and_reg, and_next;
  logic gate_reg, gate_next;

  // dividers
  logic [10:0] slow_div_reg, slow_div_next;
  logic [FAST_DIV_W-1:0] fast_div_reg, fast_div_next;
  logic [SLOW_UNIT_W-1:0] slow_unit_reg, slow_unit_next;

  // combinational terms
  logic setup_phase, access_done, wr_access, rd_access;
  logic addr_mapped;
  logic clear_pulse;
  logic slow_tick;
  logic [1:0] prescale;
  logic [3:0] fast_exp, slow_exp;
  logic [FAST_DIV_W-1:0] fast_mask;
  logic [SLOW_UNIT_W-1:0] slow_mask;
  logic unit_tick;
  logic internal_gate;
  logic gate_now;
  logic and_now;
  logic count_edge;
  logic gate_rise, gate_fall;
  logic gate_irq_event;
  logic wrap_event;
  irq_bits_t irq_pending;
  logic [31:0] read_word;

  assign setup_phase = i_psel && !i_penable;
  assign access_done = i_psel && i_penable;
  assign wr_access = access_done && i_pwrite;
  assign rd_access = access_done && !i_pwrite;

  always_comb begin
    case (i_paddr)
      OFS_CTRL, OFS_GATE_PERIOD, OFS_COUNT, OFS_STATUS,
      OFS_IRQ_STATUS, OFS_IRQ_MASK: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  assign clear_pulse = wr_access && (i_paddr == OFS_CTRL) && i_pwdata[CTRL_CLEAR_BIT];

  // free-running internal divider, shared by the gate generator
  assign slow_tick = (slow_div_reg == SLOW_DIV_LAST);
  assign prescale = (timer1_control_one_reg.gate_prescale_select > PRESCALE_MAX) ?
                    PRESCALE_MAX : timer1_control_one_reg.gate_prescale_select;
  assign fast_exp = FAST_BASE_EXP + {2'h0, prescale};
  assign slow_exp = SLOW_BASE_EXP + {2'h0, prescale};
  assign fast_mask = FAST_DIV_W'((32'h1 << fast_exp) - 32'h1); // RQ11
  assign slow_mask = SLOW_UNIT_W'((32'h1 << slow_exp) - 32'h1); // RQ11

  always_comb begin
    if (timer1_control_one_reg.divider_stage_select) begin
      unit_tick = slow_tick && ((slow_unit_reg & slow_mask) == slow_mask);
    end else begin
      unit_tick = ((fast_div_reg & fast_mask) == fast_mask);
    end
  end

  always_comb begin
    fast_div_next = fast_div_reg + FAST_DIV_W'(1);
    slow_div_next = slow_tick ? 11'h000 : slow_div_reg + 11'h001;
    slow_unit_next = slow_tick ? slow_unit_reg + SLOW_UNIT_W'(1) : slow_unit_reg;
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      fast_div_reg <= '0;
      slow_div_reg <= 11'h000;
      slow_unit_reg <= '0;
    end else begin
      fast_div_reg <= fast_div_next;
      slow_div_reg <= slow_div_next;
      slow_unit_reg <= slow_unit_next;
    end
  end

  window_gate_gen u_gate_gen (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_run(timer1_control_one_reg.run),
    .i_unit_tick(unit_tick),
    .i_period(gate_period_setting_reg),
    .o_gate(internal_gate)
  );

  // gate selection and edge counting
  always_comb begin
    if (timer1_control_one_reg.gate_source_select == GATE_SRC_PIN) begin
      gate_now = timer1_control_one_reg.run && i_external_gate_input; // RQ3
    end else begin
      gate_now = timer1_control_one_reg.run && internal_gate;
    end
  end

  // events pass only with external source and gate high RQ1 RQ2
  assign and_now = i_event_count_input && gate_now && timer1_control_one_reg.source_clock_select;
  // falling edge of the and, a gate fall with event high counts once RQ14
  assign count_edge = and_reg && !and_now;
  assign gate_rise = !gate_reg && gate_now;
  assign gate_fall = gate_reg && !gate_now;
  assign gate_irq_event = gate_fall ||
                          (timer1_control_one_reg.gate_irq_edge_select && gate_rise); // RQ4
  assign wrap_event = count_edge && (count_result_value_reg == CNT_MAX);

  always_comb begin
    and_next = and_now;
    gate_next = gate_now;
    count_result_value_next = count_result_value_reg; // RQ15
    count_overflow_flag_next = count_overflow_flag_reg;
    if (clear_pulse) begin
      count_result_value_next = CNT_ZERO; // RQ5
      count_overflow_flag_next = 1'b0; // RQ9
    end else if (count_edge) begin
      count_result_value_next = count_result_value_reg + CNT_W'(1); // RQ6
    end
    if (wrap_event) begin
      count_overflow_flag_next = 1'b1; // RQ8
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      and_reg <= 1'b0;
      gate_reg <= 1'b0;
      count_result_value_reg <= CNT_ZERO;
      count_overflow_flag_reg <= 1'b0;
    end else begin
      and_reg <= and_next;
      gate_reg <= gate_next;
      count_result_value_reg <= count_result_value_next;
      count_overflow_flag_reg <= count_overflow_flag_next;
    end
  end

  // register read mux
  always_comb begin
    read_word = 32'h0000_0000;
    case (i_paddr)
      OFS_CTRL: read_word[7:0] = timer1_control_one_reg;
      OFS_GATE_PERIOD: read_word[7:0] = gate_period_setting_reg;
      OFS_COUNT: read_word[CNT_W-1:0] = count_result_value_reg;
      OFS_STATUS: begin
        read_word[STAT_GATE_BIT] = gate_reg; // RQ7
        read_word[STAT_OVF_BIT] = count_overflow_flag_reg;
      end
      OFS_IRQ_STATUS: read_word[1:0] = irq_status_reg;
      OFS_IRQ_MASK: read_word[1:0] = irq_mask_reg;
      default: read_word = 32'h0000_0000;
    endcase
  end

  // control and gate period registers
  always_comb begin
    timer1_control_one_next = timer1_control_one_reg;
    gate_period_setting_next = gate_period_setting_reg;
    if (wr_access) begin
      case (i_paddr)
        OFS_CTRL: timer1_control_one_next = i_pwdata[7:0];
        OFS_GATE_PERIOD: gate_period_setting_next = i_pwdata[7:0]; // RQ13
        default: gate_period_setting_next = gate_period_setting_reg;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer1_control_one_reg <= CTRL_RESET;
      gate_period_setting_reg <= PERIOD_RESET;
    end else begin
      timer1_control_one_reg <= timer1_control_one_next;
      gate_period_setting_reg <= gate_period_setting_next;
    end
  end

  // sticky interrupt bits; a read clears only the bits it returned,
  // so an event landing after the setup capture is not lost
  always_comb begin
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    if (wr_access && (i_paddr == OFS_IRQ_MASK)) begin
      irq_mask_next = i_pwdata[1:0];
    end
    if (rd_access && (i_paddr == OFS_IRQ_STATUS)) begin
      irq_status_next = irq_status_reg & ~prdata_reg[1:0];
    end
    if (gate_irq_event) begin
      irq_status_next.gate_edge = 1'b1; // RQ4
    end
    if (wrap_event) begin
      irq_status_next.overflow = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // apb answer captured in the setup cycle
  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_phase) begin
      prdata_next = i_pwrite ? 32'h0000_0000 : read_word;
      pslverr_next = !addr_mapped;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = access_done && pslverr_reg;
  // level interrupt while any unmasked sticky bit is set
  assign irq_pending = irq_status_reg & irq_mask_reg;
  assign o_timer1_interrupt = |irq_pending;
endmodule

// *** dv/freq_meas_monitor.sv ***
// apb port assertions of the frequency counter
// bound below to the top module, sees its ports only
`timescale 1ns/10ps
module freq_meas_monitor (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr
);
  import freq_meas_pkg::*;
  logic acc;
  logic rdx;
  assign acc = i_psel & i_penable;
  assign rdx = acc & ~i_pwrite;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  a_ready_high: assert property (o_pready) else $error("pready low");
  a_unmapped_err: assert property (acc && i_paddr > OFS_IRQ_MASK
    |-> o_pslverr && o_prdata == 32'h0) else $error("unmapped not refused");
  a_mapped_ok: assert property (acc && i_paddr[1:0] == 2'h0 && i_paddr <= OFS_IRQ_MASK
    |-> !o_pslverr) else $error("mapped refused");
  a_idle_no_err: assert property (!i_psel |-> !o_pslverr) else $error("idle error");
  a_write_data_zero: assert property (acc && i_pwrite |-> o_prdata == 32'h0)
    else $error("data on write");
  a_count_width:
    assert property (rdx && i_paddr == OFS_COUNT |-> o_prdata[31:18] == 14'h0)
    else $error("count too wide");
  a_status_flags:
    assert property (rdx && i_paddr == OFS_STATUS |-> o_prdata[31:2] == 30'h0)
    else $error("status too wide");
  a_clear_bit_zero:
    assert property (rdx && i_paddr == OFS_CTRL |-> o_prdata[31:8] == 24'h0)
    else $error("clear bit reads one");
endmodule
bind gated_frequency_measurement freq_meas_monitor freq_meas_monitor_i (.i_mclk(i_mclk),
  .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

// *** dv/pulse_source_model.sv ***
// measured pulse source and external gate driver
// assumes requests change just after a rising edge
`timescale 1ns/10ps
module pulse_source_model (
  input wire logic i_mclk,
  input wire logic i_run,
  input wire logic i_hold,
  input wire logic i_gate_req,
  output logic o_event,
  output logic o_gate
);
  logic [1:0] phase_reg;
  always_ff @(posedge i_mclk) begin
    phase_reg <= i_run ? phase_reg + 2'h1 : 2'h0;
    o_gate <= i_gate_req;
  end
  // square wave of four cycles, or held high
  assign o_event = i_hold | (i_run & phase_reg[1]);
endmodule

// *** dv/tb_gated_frequency_measurement.sv ***
// self-checking bench of the gated frequency counter
// drives apb and the pulse source model from one 50 mhz clock
`timescale 1ns/10ps
module tb_gated_frequency_measurement;
  import freq_meas_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, run = 0, hold = 0, gate_req = 0;
  logic pready, pslverr, irq, err, ev, gate;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, c;
  time t0, t1;
  int fails = 0, checks_done = 0;
  gated_frequency_measurement gated_frequency_measurement_i (.i_mclk(clk), .i_rst_b(rst_b),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_event_count_input(ev),
    .i_external_gate_input(gate), .o_timer1_interrupt(irq));
  pulse_source_model pulse_source_model_i (.i_mclk(clk), .i_run(run), .i_hold(hold),
    .i_gate_req(gate_req), .o_event(ev), .o_gate(gate));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      check(32'h0, 32'h1, "pready timeout");
      report_and_stop();
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp, "read");
  endtask
  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, {31'h0, v}, "irq");
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic window(input int n, input logic tail);
    gate_req <= 1'b1;
    pause(4);
    if (n > 0) begin
      run <= 1'b1;
      pause(4 * n);
      run <= 1'b0;
    end
    hold <= tail;
    pause(4);
    gate_req <= 1'b0;
    pause(4);
    hold <= 1'b0;
    pause(4);
  endtask
  task automatic wait_gate(input logic v, output time t);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[STAT_GATE_BIT] !== v && n < 4000);
    t = $time;
    if (n >= 4000) begin
      check(32'h0, 32'h1, "gate flag timeout");
      report_and_stop();
    end
  endtask
  task automatic near(input time ta, input time tb, input int exp);
    int cyc;
    cyc = int'((tb - ta) / 20);
    check({31'h0, cyc >= exp - 6 && cyc <= exp + 6}, 32'h1, "gate period");
  endtask
  task automatic t_reset;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_GATE_PERIOD, 32'h0);
    rdc(OFS_COUNT, 32'h0);
    rdc(OFS_IRQ_MASK, 32'h0);
    rdc(12'h018, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    irq_is(1'b0);
  endtask
  task automatic t_ext;
    apb(1'b1, OFS_CTRL, 32'h09);
    window(2, 1'b0);
    rdc(OFS_COUNT, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h89);
    window(5, 1'b0);
    rdc(OFS_COUNT, 32'h5);
    window(3, 1'b0);
    rdc(OFS_COUNT, 32'h8);
    window(0, 1'b1);
    rdc(OFS_COUNT, 32'h9);
    run <= 1'b1;
    pause(16);
    run <= 1'b0;
    rdc(OFS_COUNT, 32'h9);
    gate_req <= 1'b1;
    pause(4);
    rdc(OFS_STATUS, 32'h1);
    gate_req <= 1'b0;
    pause(4);
    rdc(OFS_STATUS, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h189);
    rdc(OFS_COUNT, 32'h0);
  endtask
  task automatic t_edges;
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h81);
    gate_req <= 1'b1;
    irq_is(1'b0);
    gate_req <= 1'b0;
    irq_is(1'b1);
    rdc(OFS_IRQ_STATUS, 32'h1);
    irq_is(1'b0);
    apb(1'b1, OFS_CTRL, 32'h89);
    gate_req <= 1'b1;
    irq_is(1'b1);
    rdc(OFS_IRQ_STATUS, 32'h1);
    gate_req <= 1'b0;
    pause(4);
    rdc(OFS_IRQ_STATUS, 32'h1);
  endtask
  task automatic t_internal;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_GATE_PERIOD, 32'hff);
    apb(1'b1, OFS_CTRL, 32'h83);
    run <= 1'b1;
    t1 = $time;
    wait_gate(1'b1, t0);
    check({31'h0, (t0 - t1) / 20 <= 4106}, 32'h1, "first window lag");
    wait_gate(1'b0, t1);
    near(t0, t1, 4096);
    apb(1'b1, OFS_GATE_PERIOD, 32'hef);
    apb(1'b0, OFS_COUNT, 32'h0);
    c = rd;
    pause(40);
    rdc(OFS_COUNT, c);
    irq_is(1'b1);
    wait_gate(1'b1, t0);
    near(t1, t0, 4096);
    wait_gate(1'b0, t1);
    near(t0, t1, 4096);
    wait_gate(1'b1, t0);
    near(t1, t0, 8192);
    run <= 1'b0;
  endtask
  initial begin
    pause(3);
    rst_b <= 1'b1;
    pause(4);
    t_reset();
    t_ext();
    t_edges();
    t_internal();
    report_and_stop();
  end
endmodule
